// file: core/btc_pkg.sv
// ==========================================================================
// Bus trace capture: shared constants and types
// ==========================================================================
package btc_pkg;

  // ========================================================================
  // Buffer geometry
  // ========================================================================
  localparam int DEPTH  = 32768;       // Records kept from the last run
  localparam int PTR_W  = 15;          // Ring pointer width
  localparam int ADDR_W = 24;          // Six hex digits of address
  localparam int DATA_W = 16;          // Data bus, 8 or 16 bits used

  // ========================================================================
  // Register offsets (byte addresses, one word each)
  // ========================================================================
  localparam logic [7:0] REG_CTRL    = 8'h00; // Mode and tick select
  localparam logic [7:0] REG_SUPP    = 8'h04; // Cycle kinds to drop
  localparam logic [7:0] REG_EVT     = 8'h08; // Event presence and masks
  localparam logic [7:0] REG_DELAY   = 8'h0C; // Delayed stop count
  localparam logic [7:0] REG_STATUS  = 8'h10; // State, wrap, pointer
  localparam logic [7:0] REG_STOPOFS = 8'h14; // Records after stop cycle
  localparam logic [7:0] REG_RDIDX   = 8'h18; // How far back to read
  localparam logic [7:0] REG_REC0    = 8'h1C; // Record word, bits 31:0
  localparam logic [7:0] REG_REC1    = 8'h20; // Record word, bits 63:32
  localparam logic [7:0] REG_REC2    = 8'h24; // Record word, bits 73:64

  // ========================================================================
  // Field positions
  // ========================================================================
  localparam int CTRL_FREE  = 0;       // Unconditional capture
  localparam int CTRL_STOP  = 1;       // Immediate stop enable
  localparam int CTRL_DSTOP = 2;       // Delayed stop enable
  localparam int CTRL_TS_LO = 4;       // Tick select, 4 bits
  localparam int EVT_PRES   = 0;       // Event point exists, 4 bits
  localparam int EVT_START  = 4;       // Start events, 4 bits
  localparam int EVT_STOP   = 8;       // Immediate stop events, 4 bits
  localparam int EVT_DSTOP  = 12;      // Delayed stop events, 4 bits
  localparam int STAT_WRAP  = 4;       // Buffer wrapped once
  localparam int STAT_PTR   = 16;      // Write pointer, 15 bits

  // ========================================================================
  // Reset values
  // ========================================================================
  localparam logic [31:0] CTRL_RST  = 32'h0000_0001; // Free trace on
  localparam logic [31:0] ZERO_RST  = 32'h0000_0000;

  // ========================================================================
  // Cycle kinds and clock count coding
  // ========================================================================
  localparam int          N_KINDS      = 5;     // Suppressible kinds
  localparam logic [3:0]  CLK_MAX      = 4'h8;  // Longest coded cycle
  localparam logic [2:0]  CLK_OVF_CODE = 3'h7;

  // ========================================================================
  // Timestamp tick periods (ns); code 0 is disabled
  // ========================================================================
  localparam int unsigned MCLK_NS = 100;   // 10 MHz system clock
  localparam int unsigned TS_N    = 10;
  localparam int unsigned TS_PERIOD_NS [0:9] = '{0, 125, 250, 500, 1000,
    2000, 4000, 8000, 16000, 100000};
  localparam int          ACC_W   = 17;    // Holds largest period

  // ========================================================================
  // Types
  // ========================================================================
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              rd_wr;    // 1 read, 0 write
    logic [2:0]        area;     // ROM, RAM, I/O 8/16, external 8/16, ctrl RAM
    logic [2:0]        kind;     // 0 prefetch_cycle, 1 data, 2 refresh,
                                 // 3 transfer_controller_cycle,
                                 // 4 direct_memory_access_cycle
    logic [3:0]        clocks;   // Clocks in the bus cycle
    logic [3:0]        probes;   // Probe 4 in bit 3
    logic              nmi;
    logic [7:0]        irq;
  } btc_bus_t;

  typedef struct packed {
    logic              ts_mode;  // Extra word holds a timestamp
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              rd_wr;
    logic [31:0]       extra;
  } btc_rec_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,   // Not running or halted
    ST_ARMED   = 4'b0010,   // Waiting for a start event
    ST_CAPTURE = 4'b0100,   // Recording
    ST_DELAY   = 4'b1000    // Recording out the stop delay
  } btc_state_t;

endpackage

// file: core/btc_ring.sv
`timescale 1ns/1ps
// ==========================================================================
// Circular trace store
// ==========================================================================
module btc_ring
  import btc_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             clear,    // Program start
  input  wire logic             wr_en,    // Store one record
  input  btc_pkg::btc_rec_t     wr_rec,
  input  wire logic [PTR_W-1:0] rd_back,  // 0 newest, 1 one older
  output btc_pkg::btc_rec_t     rd_rec,
  output logic      [PTR_W-1:0] wptr,
  output logic                  wrapped
);
  btc_rec_t         mem [0:DEPTH-1];      // No reset: contents are data
  btc_rec_t         rd_q;
  logic [PTR_W-1:0] wptr_ff;
  logic             wrap_ff;
  logic [PTR_W-1:0] rd_addr;

  // Newest sits one below the write pointer; modulo math wraps for free
  assign rd_addr = wptr_ff - PTR_W'(1) - rd_back;

  // ========================================================================
  // Storage, newest overwrites oldest
  // ========================================================================
  always_ff @(posedge mclk)
  begin
    if (wr_en)
      mem[wptr_ff] <= wr_rec;
    rd_q <= mem[rd_addr];
  end

  // ========================================================================
  // Pointer and wrap flag
  // ========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_ff <= '0;
      wrap_ff <= 1'b0;
    end
    else if (clear)
    begin
      wptr_ff <= '0;
      wrap_ff <= 1'b0;
    end
    else if (wr_en)
    begin
      wptr_ff <= wptr_ff + PTR_W'(1);
      if (&wptr_ff)
        wrap_ff <= 1'b1;
    end
  end

  assign rd_rec  = rd_q;
  assign wptr    = wptr_ff;
  assign wrapped = wrap_ff;
endmodule

// file: core/btc_top.sv
`timescale 1ns/1ps
module btc_top
  import btc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        run,        // User program executing
  input  wire logic [3:0]  evt,        // Event point hits, this clock
  input  wire logic        bus_cyc,    // Pin: one bus cycle done
  input  btc_pkg::btc_bus_t bus_pins,  // Pin: sampled bus values
  output logic             capturing   // Recording now
);
  // ========================================================================
  // Reset release and pin synchronisers
  // ========================================================================
  logic        rst_a_ff;               // First stage of reset release
  logic        rst_b_ff;               // Release copy used everywhere
  logic        cyc_a_ff;
  logic        cyc_b_ff;
  btc_bus_t    bus_a_ff;
  btc_bus_t    bus_b_ff;
  logic        run_ff;                 // Previous run level

  // Assert at once, release after two edges
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end
    else
    begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end

  // Bus pins are asynchronous; both stages delay strobe and data alike
  always_ff @(posedge mclk or negedge rst_b_ff)
  begin
    if (!rst_b_ff)
    begin
      cyc_a_ff <= 1'b0;
      cyc_b_ff <= 1'b0;
      bus_a_ff <= '0;
      bus_b_ff <= '0;
      run_ff   <= 1'b0;
    end
    else
    begin
      cyc_a_ff <= bus_cyc;
      cyc_b_ff <= cyc_a_ff;
      bus_a_ff <= bus_pins;
      bus_b_ff <= bus_a_ff;
      run_ff   <= run;
    end
  end

  logic run_start;                     // Program started this cycle
  assign run_start = run && !run_ff;

  // ========================================================================
  // Registers written by software
  // ========================================================================
  logic [31:0]      ctrl_ff;
  logic [N_KINDS-1:0] supp_ff;
  logic [15:0]      evtcfg_ff;
  logic [15:0]      delay_ff;
  logic [PTR_W-1:0] rdidx_ff;

  // Plain write port; unmapped offsets are ignored
  always_ff @(posedge mclk or negedge rst_b_ff)
  begin
    if (!rst_b_ff)
    begin
      ctrl_ff   <= CTRL_RST;
      supp_ff   <= '0;
      evtcfg_ff <= '0;
      delay_ff  <= '0;
      rdidx_ff  <= '0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        REG_CTRL:  ctrl_ff   <= reg_wdata;
        REG_SUPP:  supp_ff   <= reg_wdata[N_KINDS-1:0];
        REG_EVT:   evtcfg_ff <= reg_wdata[15:0];
        REG_DELAY: delay_ff  <= reg_wdata[15:0];
        REG_RDIDX: rdidx_ff  <= reg_wdata[PTR_W-1:0];
        default:   ;                   // Read-only or unmapped
      endcase
    end
  end

  // ========================================================================
  // Condition decode
  // ========================================================================
  logic       free_mode;
  logic [3:0] present;
  logic [3:0] start_m;
  logic       start_cfg;
  logic       start_hit;
  logic       stop_hit;
  logic       dstop_hit;
  logic       suppressed;
  logic       take;                    // Write a record this cycle
  logic [3:0] ts_sel;
  logic       ts_on;

  assign free_mode = ctrl_ff[CTRL_FREE];
  assign present   = evtcfg_ff[EVT_PRES +: 4];
  // Range start events are ignored in free mode
  assign start_m   = free_mode ? 4'h0
                   : (evtcfg_ff[EVT_START +: 4] & present);
  assign start_cfg = |start_m;
  assign start_hit = |(start_m & evt);
  // A deleted event point no longer stops anything
  assign stop_hit  = ctrl_ff[CTRL_STOP]
                   && |(evtcfg_ff[EVT_STOP +: 4] & present & evt);
  assign dstop_hit = ctrl_ff[CTRL_DSTOP]
                   && |(evtcfg_ff[EVT_DSTOP +: 4] & present & evt);
  // Kinds beyond the table are never suppressed
  assign suppressed = (32'(bus_b_ff.kind) < N_KINDS)
                    && supp_ff[bus_b_ff.kind[2:0]];
  assign ts_sel = ctrl_ff[CTRL_TS_LO +: 4];
  assign ts_on  = (ts_sel != 4'h0) && (32'(ts_sel) < TS_N);

  // ========================================================================
  // Capture state machine
  // ========================================================================
  btc_state_t  state_ff;
  logic [15:0] dly_ff;                 // Records left in the delay
  logic [15:0] stopofs_ff;             // Records taken after stop cycle

  assign take = run && cyc_b_ff && !suppressed
             && (state_ff == ST_CAPTURE || state_ff == ST_DELAY);

  always_ff @(posedge mclk or negedge rst_b_ff)
  begin
    if (!rst_b_ff)
    begin
      state_ff <= ST_IDLE;
      dly_ff   <= 16'h0000;
    end
    else if (!run)
    begin
      state_ff <= ST_IDLE;
    end
    else if (run_start)
    begin
      // No start events configured means record from the first cycle
      state_ff <= start_cfg ? ST_ARMED : ST_CAPTURE;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:    state_ff <= ST_IDLE;   // Halted until next run
        ST_ARMED:
          if (stop_hit)
            state_ff <= ST_IDLE;
          else if (start_hit)
            state_ff <= ST_CAPTURE;
        ST_CAPTURE:
          if (stop_hit)
            state_ff <= ST_IDLE;
          else if (dstop_hit && delay_ff == 16'h0000)
            state_ff <= ST_IDLE;           // Zero delay acts at once
          else if (dstop_hit)
          begin
            state_ff <= ST_DELAY;
            dly_ff   <= delay_ff;
          end
        ST_DELAY:
          if (stop_hit)
            state_ff <= ST_IDLE;
          else if (take)
          begin
            dly_ff <= dly_ff - 16'h0001;
            if (dly_ff == 16'h0001)
              state_ff <= ST_IDLE;
          end
        default:    state_ff <= ST_IDLE;
      endcase
    end
  end

  // Count how far the stop cycle lies behind the newest record
  always_ff @(posedge mclk or negedge rst_b_ff)
  begin
    if (!rst_b_ff)
      stopofs_ff <= 16'h0000;
    else if (run_start || (state_ff == ST_CAPTURE && dstop_hit))
      stopofs_ff <= 16'h0000;
    else if (take && state_ff == ST_DELAY)
      stopofs_ff <= stopofs_ff + 16'h0001;
  end

  // ========================================================================
  // Record assembly
  // ========================================================================
  logic [31:0] ts_count;
  btc_rec_t    rec;
  btc_rec_t    rd_rec;
  logic [2:0]  clk_code;
  logic        clk_ovf;
  logic [PTR_W-1:0] wptr;
  logic        wrapped;

  btc_tstamp u_tstamp (
    .mclk  (mclk),
    .rst_n (rst_b_ff),
    .clear (run_start),
    .sel   (ts_sel),
    .count (ts_count)
  );

  // Clock count kept as value minus one; longer cycles get the mark
  always_comb
  begin
    clk_ovf  = bus_b_ff.clocks > CLK_MAX;
    if (clk_ovf)
      clk_code = CLK_OVF_CODE;
    else if (bus_b_ff.clocks == 4'h0)
      clk_code = 3'h0;
    else
      clk_code = 3'(bus_b_ff.clocks - 4'h1);
  end

  always_comb
  begin
    rec         = '0;
    rec.ts_mode = ts_on;
    rec.addr    = bus_b_ff.addr;
    rec.data    = bus_b_ff.data;
    rec.rd_wr   = bus_b_ff.rd_wr;
    // Timestamp shares the word, so the detail fields drop out
    if (ts_on)
      rec.extra = ts_count;
    else
      rec.extra = {9'h000, bus_b_ff.area, bus_b_ff.kind,
                   clk_code, clk_ovf,
                   bus_b_ff.probes,
                   bus_b_ff.nmi, bus_b_ff.irq};
  end

  btc_ring u_ring (
    .mclk    (mclk),
    .rst_n   (rst_b_ff),
    .clear   (run_start),
    .wr_en   (take),
    .wr_rec  (rec),
    .rd_back (rdidx_ff),
    .rd_rec  (rd_rec),
    .wptr    (wptr),
    .wrapped (wrapped)
  );

  // ========================================================================
  // Read port, data one cycle after the strobe
  // ========================================================================
  logic [31:0] rdata_ff;

  always_ff @(posedge mclk or negedge rst_b_ff)
  begin
    if (!rst_b_ff)
      rdata_ff <= ZERO_RST;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CTRL:    rdata_ff <= ctrl_ff;
        REG_SUPP:    rdata_ff <= {27'h0, supp_ff};
        REG_EVT:     rdata_ff <= {16'h0000, evtcfg_ff};
        REG_DELAY:   rdata_ff <= {16'h0000, delay_ff};
        REG_STATUS:  rdata_ff <= {1'b0, wptr, 11'h000, wrapped,
                                  state_ff};
        REG_STOPOFS: rdata_ff <= {16'h0000, stopofs_ff};
        REG_RDIDX:   rdata_ff <= {17'h00000, rdidx_ff};
        REG_REC0:    rdata_ff <= rd_rec[31:0];
        REG_REC1:    rdata_ff <= rd_rec[63:32];
        REG_REC2:    rdata_ff <= {22'h000000, rd_rec[73:64]};
        default:     rdata_ff <= ZERO_RST; // Unmapped reads zero
      endcase
    end
    else
      rdata_ff <= ZERO_RST;
  end

  assign reg_rdata = rdata_ff;
  assign capturing = (state_ff == ST_CAPTURE) || (state_ff == ST_DELAY);

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b_ff);

  run_clears_a: assert property ($rose(run) |=> wptr == '0
    && !wrapped && ts_count == 32'h0000_0000)
    else $error("start of run did not clear buffer and timestamp");
  halt_idle_a: assert property (!run |=> state_ff == ST_IDLE)
    else $error("capture kept running after program halt");
  free_start_a: assert property (run_start && free_mode
    |=> state_ff == ST_CAPTURE)
    else $error("free mode did not begin capturing at run");
  event_arm_a: assert property (run_start && start_cfg
    |=> state_ff == ST_ARMED)
    else $error("configured start events did not arm");
  suppress_a: assert property (cyc_b_ff && suppressed && !run_start
    |=> wptr == $past(wptr))
    else $error("suppressed cycle was recorded");
  ptr_step_a: assert property (take
    |=> wptr == $past(wptr) + PTR_W'(1))
    else $error("pointer did not advance by one record");
  delay_load_a: assert property (state_ff == ST_CAPTURE && run
    && !run_start && !stop_hit && dstop_hit && delay_ff != 16'h0000
    |=> state_ff == ST_DELAY && dly_ff == $past(delay_ff))
    else $error("delayed stop did not load its count");
  stop_now_a: assert property (run && !run_start && stop_hit
    && capturing |=> state_ff == ST_IDLE)
    else $error("immediate stop did not halt capture");
  ts_field_a: assert property (ts_on |-> rec.extra == ts_count)
    else $error("timestamp not placed in record");
  clk_ovf_a: assert property (bus_b_ff.clocks > CLK_MAX
    |-> rec.ts_mode || rec.extra[13] == 1'b1)
    else $error("long bus cycle lacks overflow mark");

  wrap_c: cover property (take && &wptr ##1 wrapped);
  delay_end_c: cover property (state_ff == ST_DELAY ##1
    state_ff == ST_IDLE);
  armed_go_c: cover property (state_ff == ST_ARMED ##1
    state_ff == ST_CAPTURE);
endmodule

// file: core/btc_tstamp.sv
`timescale 1ns/1ps
// ==========================================================================
// Timestamp counter with fractional tick divider
// ==========================================================================
module btc_tstamp
  import btc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clear,   // Program start
  input  wire logic [3:0]  sel,     // Tick code, 0 disabled
  output logic      [31:0] count
);
  logic [ACC_W-1:0] acc_ff;         // Nanoseconds toward the next tick
  logic [ACC_W-1:0] nxt_sum;
  logic [ACC_W-1:0] period;
  logic             sel_ok;
  logic [31:0]      count_ff;

  // Periods shorter than the clock cannot occur, so one tick per cycle
  // at most; the remainder carries so the mean rate stays exact.
  assign sel_ok  = (sel != 4'h0) && (32'(sel) < TS_N);
  assign period  = sel_ok ? ACC_W'(TS_PERIOD_NS[sel]) : '0;
  assign nxt_sum = acc_ff + ACC_W'(MCLK_NS);

  // ========================================================================
  // Divider and counter
  // ========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_ff   <= '0;
      count_ff <= 32'h0000_0000;
    end
    else if (clear)
    begin
      acc_ff   <= '0;
      count_ff <= 32'h0000_0000;
    end
    else if (!sel_ok)
    begin
      acc_ff <= '0;                 // Disabled: count holds, remainder cleared
    end
    else if (nxt_sum >= period)
    begin
      acc_ff   <= nxt_sum - period;
      count_ff <= count_ff + 32'h0000_0001;
    end
    else
    begin
      acc_ff <= nxt_sum;
    end
  end

  assign count = count_ff;
endmodule

// file: verif/btc_bus_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Target bus: one strobe per bus cycle, values held until the next one
// ==========================================================================
module btc_bus_model
  import btc_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  go,       // Finish one bus cycle now
  input  btc_bus_t   val,      // Values of that cycle
  output logic       bus_cyc,
  output btc_bus_t   bus_pins
);
  // Pins change with the strobe so both cross the sync flops together
  always @(posedge mclk)
  begin
    bus_cyc <= go;
    if (go)
      bus_pins <= val;
  end
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench: free trace, record layout, suppression, halt and stop
// ==========================================================================
module tb;
  import btc_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        run = 1'b0, go = 1'b0, bus_cyc, capturing;
  logic [3:0]  evt = 4'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv, seed = 32'h56;
  btc_bus_t    bv = '0, bus_pins, q[$];
  int          n_fail = 0, checked = 0, np = 0;
  always #50 mclk = ~mclk;
  btc_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .run(run), .evt(evt), .bus_cyc(bus_cyc),
    .bus_pins(bus_pins), .capturing(capturing));
  btc_bus_model model (.mclk(mclk), .go(go), .val(bv), .bus_cyc(bus_cyc),
    .bus_pins(bus_pins));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected extra word; long cycles saturate at the overflow code
  function automatic logic [31:0] xword(btc_bus_t b);
    logic ov;
    logic [2:0] c;
    ov = b.clocks > CLK_MAX;
    c = ov ? CLK_OVF_CODE : (b.clocks == 4'h0 ? 3'h0 : 3'(b.clocks - 4'h1));
    return {9'h0, b.area, b.kind, c, ov, b.probes, b.nmi, b.irq};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rv = reg_rdata;
  endtask
  // Gap covers the sync flops and the two-cycle record read path
  task automatic send(input btc_bus_t b);
    @(posedge mclk);
    go <= 1'b1;
    bv <= b;
    q.push_front(b);
    @(posedge mclk);
    go <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  // Event hit lasts one clock; ends off the edge so outputs have settled
  task automatic ev(input logic [3:0] e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= 4'h0;
    @(negedge mclk);
  endtask
  task automatic ptr(input int n);
    rd(REG_STATUS);
    cmp({17'h0, rv[30:16]}, n[31:0]);
  endtask
  task automatic stop_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog: run needs well under a tenth of this
  initial
  begin
    #2000000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    btc_bus_t b;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(REG_CTRL);
    cmp(rv, CTRL_RST);
    ptr(0);
    @(posedge mclk);
    run <= 1'b1;
    repeat (2) @(negedge mclk);
    cmp({31'h0, capturing}, 32'h1);
    // Random cycles, with clock counts at and past the coded limit
    for (int k = 0; k < 10; k++)
    begin
      b = {rnd(), rnd()};
      b.kind = 3'(k % 5);
      b.area = 3'(k % 7);
      if (k < 2)
        b.clocks = 4'h8 + 4'(k);
      send(b);
      rd(REG_REC0);
      cmp(rv, xword(b));
      rd(REG_REC1);
      cmp(rv, {b.addr[14:0], b.data, b.rd_wr});
      rd(REG_REC2);
      cmp(rv, {22'h0, 1'b0, b.addr[23:15]});
    end
    rd(REG_STATUS);
    cmp(rv, 32'h000A_0004);
    wr(REG_RDIDX, 32'h3);
    repeat (2) @(posedge mclk);
    rd(REG_REC0);
    cmp(rv, xword(q[3]));
    np = 10;
    // Each kind dropped alone; its neighbour still lands
    for (int k = 0; k < 5; k++)
    begin
      wr(REG_SUPP, 32'h1 << k);
      b.kind = 3'(k);
      send(b);
      b.kind = 3'((k + 1) % 5);
      send(b);
      np++;
      ptr(np);
    end
    wr(REG_SUPP, 32'h0);
    @(posedge mclk);
    run <= 1'b0;
    repeat (2) @(negedge mclk);
    cmp({31'h0, capturing}, 32'h0);
    send(b);
    ptr(np);
    wr(REG_CTRL, 32'h3);
    wr(REG_EVT, 32'h101);
    @(posedge mclk);
    run <= 1'b1;
    repeat (2) @(posedge mclk);
    ptr(0);
    send(b);
    @(posedge mclk);
    evt <= 4'h1;
    @(posedge mclk);
    evt <= 4'h0;
    repeat (2) @(negedge mclk);
    cmp({31'h0, capturing}, 32'h0);
    send(b);
    ptr(1);
    // Free mode, 1 us ticks: sends are ten clocks apart, one tick each
    @(posedge mclk);
    run <= 1'b0;
    wr(REG_CTRL, 32'h41);
    wr(REG_EVT, 32'h11);
    wr(REG_RDIDX, 32'h0);
    @(posedge mclk);
    run <= 1'b1;
    send(b);
    send(b);
    rd(REG_REC0);
    cmp(rv, 32'h1);
    cmp({31'h0, capturing}, 32'h1);
    rd(REG_REC2);
    cmp(rv, {22'h0, 1'b1, b.addr[23:15]});
    rd(REG_REC1);
    cmp(rv, {b.addr[14:0], b.data, b.rd_wr});
    // A new run restarts the stamp from zero
    @(posedge mclk);
    run <= 1'b0;
    @(posedge mclk);
    run <= 1'b1;
    send(b);
    rd(REG_REC0);
    cmp(rv, 32'h0);
    // Event mode: start on event 1, delayed stop of two on event 2,
    // immediate stop on event 0 which is not present
    @(posedge mclk);
    run <= 1'b0;
    wr(REG_CTRL, 32'h6);
    wr(REG_EVT, 32'h4126);
    wr(REG_DELAY, 32'h2);
    @(posedge mclk);
    run <= 1'b1;
    send(b);
    ptr(0);
    ev(4'h2);
    ev(4'h1);
    cmp({31'h0, capturing}, 32'h1);
    send(b);
    ev(4'h4);
    repeat (3) send(b);
    ptr(3);
    rd(REG_STOPOFS);
    cmp(rv, 32'h2);
    cmp({31'h0, capturing}, 32'h0);
    stop_test();
  end
endmodule
